// ===== hw/tp_test_page.sv
// test-page register group: spare data pins as i/o, probe view, receiver and self-test controls
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "tp_consts.svh"

module tp_test_page (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // register port
  input  wire tp_pkg::tp_bus_req_t   bus_req,
  output logic               [7:0]   rdata,
  // host interface in use
  input  wire tp_pkg::tp_host_if_t   host_if,
  // data pins 6..0
  input  wire logic          [6:0]   pin_in,
  output logic               [6:0]   pin_out,
  output logic               [6:0]   pin_oe_n,
  // internal sources
  input  wire logic                  aux_module_clk,
  input  wire logic          [255:0] probe_buses,
  input  wire logic                  frame_delimiter_width,
  input  wire logic                  selftest_cmd,
  // controls toward the core
  output logic                       uart_aux_line_enable,
  output logic                       nonlinear_receive,
  output tp_pkg::tp_dlm_t            dlm,
  output logic                       selftest_armed,
  output logic                       selftest_run
);

  tp_pkg::tp_state_t s_q;
  tp_pkg::tp_state_t s_d;

  logic       serial_host;
  logic       narrow_port;
  logic       port_io_enable;
  logic       aux_clock_on_pin_one;
  logic [6:0] usable;
  logic [6:0] io_drive;
  logic [6:0] alt_drive;
  logic [6:0] alt_value;
  logic [7:0] probe_view;
  logic [7:0] val_read;

  // pin routing decisions from current register state
  always_comb
  begin
    serial_host          = (host_if != tp_pkg::TP_HOST_PARALLEL);
    narrow_port          = (host_if == tp_pkg::TP_HOST_SPI) ||
                           ((host_if == tp_pkg::TP_HOST_UART) && s_q.pin_en[`TP_BIT_UART_AUX]);
    usable               = narrow_port ? `TP_PINS_NARROW : `TP_PINS_ALL;
    port_io_enable       = s_q.pin_val[`TP_BIT_IO_EN] & serial_host;
    aux_clock_on_pin_one = s_q.clk_sel[`TP_BIT_AUX_CLK] & serial_host;
    io_drive             = {7{port_io_enable}} & s_q.pin_en[6:0] & usable;
    io_drive[`TP_PIN_ONE] = io_drive[`TP_PIN_ONE] & ~aux_clock_on_pin_one;
    alt_drive            = 7'h00;
    alt_value            = 7'h00;
    alt_drive[`TP_PIN_ONE] = aux_clock_on_pin_one;
    alt_value[`TP_PIN_ONE] = aux_module_clk;
  end

  // value readback: live pin levels while port i/o is on
  always_comb
  begin
    val_read = port_io_enable ? {s_q.pin_val[`TP_BIT_IO_EN], pin_in} : s_q.pin_val;
  end

  tp_probe_mux u_probe_mux (
    .probe_buses (probe_buses),
    .sel         (s_q.probe_sel[4:0]),
    .view        (probe_view)
  );

  // one output stage per data pin
  for (genvar n = 0; n < 7; n++)
  begin : g_pin
    tp_pin_cell u_cell (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .io_drive  (io_drive[n]),
      .io_value  (s_q.pin_val[n]),
      .alt_drive (alt_drive[n]),
      .alt_value (alt_value[n]),
      .pin_out   (pin_out[n]),
      .pin_oe_n  (pin_oe_n[n])
    );
  end

  // register writes, reads and derived controls
  always_comb
  begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        `TP_ADDR_CLK_SEL:   s_d.clk_sel   = bus_req.wdata & `TP_WMASK_CLK_SEL;
        `TP_ADDR_PROBE_SEL: s_d.probe_sel = bus_req.wdata;
        `TP_ADDR_PIN_EN:    s_d.pin_en    = bus_req.wdata;
        `TP_ADDR_PIN_VAL:   s_d.pin_val   = bus_req.wdata;
        `TP_ADDR_SELF_CHK:  s_d.self_chk  = bus_req.wdata & `TP_WMASK_SELF_CHK;
        default:            s_d.rdata     = 8'h00; // probe view and unmapped: write ignored
      endcase
    end
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        `TP_ADDR_CLK_SEL:    s_d.rdata = s_q.clk_sel;
        `TP_ADDR_PROBE_SEL:  s_d.rdata = s_q.probe_sel;
        `TP_ADDR_PIN_EN:     s_d.rdata = s_q.pin_en;
        `TP_ADDR_PIN_VAL:    s_d.rdata = val_read;
        `TP_ADDR_PROBE_VIEW: s_d.rdata = probe_view;
        `TP_ADDR_SELF_CHK:   s_d.rdata = s_q.self_chk;
        default:             s_d.rdata = 8'h00;
      endcase
    end
    // only the exact code arms; any other value, 0000 included, is normal operation
    s_d.armed = (s_d.self_chk[3:0] == `TP_ST_ARM);
    s_d.run   = s_q.armed & selftest_cmd;
    // delimiter mode; adjust set with width clear falls back to minimum
    s_d.dlm = '0;
    if (s_d.self_chk[`TP_BIT_DLM_ADJ] && frame_delimiter_width)
      s_d.dlm.mode = tp_pkg::TP_DLM_TRIM;
    else if (frame_delimiter_width)
      s_d.dlm.mode = tp_pkg::TP_DLM_MAX;
    else
      s_d.dlm.mode = tp_pkg::TP_DLM_MIN;
    unique case (s_d.dlm.mode)
      tp_pkg::TP_DLM_TRIM:
      begin
        s_d.dlm.sof_low_etu   = `TP_SOF_LOW_ETU;
        s_d.dlm.low_minus_cyc = `TP_TRIM_CYC;
        s_d.dlm.sof_high_etu  = `TP_SOF_HIGH_ETU;
        s_d.dlm.high_plus_cyc = `TP_TRIM_CYC;
      end
      tp_pkg::TP_DLM_MAX:  s_d.dlm.sof_low_etu = 4'h0;
      tp_pkg::TP_DLM_MIN:  s_d.dlm.sof_low_etu = 4'h0;
    endcase
  end

  // state register; value register clears so no pin is driven after reset
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q.clk_sel   <= `TP_RST_CLK_SEL;
      s_q.probe_sel <= `TP_RST_PROBE_SEL;
      s_q.pin_en    <= `TP_RST_PIN_EN;
      s_q.pin_val   <= `TP_RST_PIN_VAL;
      s_q.self_chk  <= `TP_RST_SELF_CHK;
      s_q.rdata     <= 8'h00;
      s_q.armed     <= 1'b0;
      s_q.run       <= 1'b0;
      s_q.dlm       <= '{mode: tp_pkg::TP_DLM_MIN, default: 4'h0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign rdata                = s_q.rdata;
  assign uart_aux_line_enable = s_q.pin_en[`TP_BIT_UART_AUX];
  assign nonlinear_receive    = s_q.self_chk[`TP_BIT_NONLIN];
  assign dlm                  = s_q.dlm;
  assign selftest_armed       = s_q.armed;
  assign selftest_run         = s_q.run;

  // aux line bit write reaches the output next cycle
  chk_uart_aux_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_req.wr && bus_req.addr == `TP_ADDR_PIN_EN && !bus_req.wdata[7]) |=> !uart_aux_line_enable)
    else $error("uart aux lines not disabled");

  // a parallel host never sees general i/o drivers
  chk_parallel_no_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (host_if == tp_pkg::TP_HOST_PARALLEL) |=> (pin_oe_n == 7'h7f))
    else $error("pin driven under parallel host");

  // spi keeps pins 5 and 6 as inputs
  chk_narrow_pins: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (host_if == tp_pkg::TP_HOST_SPI) |=> (pin_oe_n[6:5] == 2'h3))
    else $error("pin 5 or 6 driven under spi");

  // enabled pin drives the stored value
  chk_pin_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (serial_host && s_q.pin_val[7] && s_q.pin_en[0])
    |=> (!pin_oe_n[0] && pin_out[0] == $past(s_q.pin_val[0])))
    else $error("pin 0 not driving its value");

  // port i/o off leaves pin 0 floating
  chk_io_off_float: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!s_q.pin_val[7] && !s_q.clk_sel[3]) |=> pin_oe_n[0])
    else $error("pin 0 driven with port i/o off");

  // aux clock owns pin one
  chk_pin_one_clock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (serial_host && s_q.clk_sel[3]) |=> (!pin_oe_n[1] && pin_out[1] == $past(aux_module_clk)))
    else $error("aux clock missing on pin one");

  // value read shows live pins while port i/o is on
  chk_value_readback: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_req.rd && bus_req.addr == `TP_ADDR_PIN_VAL && port_io_enable)
    |=> (rdata == {1'b1, $past(pin_in)}))
    else $error("pin value read not live");

  // probe view read returns selected bus
  chk_probe_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_req.rd && bus_req.addr == `TP_ADDR_PROBE_VIEW) |=> (rdata == $past(probe_view)))
    else $error("probe view read wrong");

  // nonlinear bit follows a write
  chk_nonlin_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_req.wr && bus_req.addr == `TP_ADDR_SELF_CHK)
    |=> (nonlinear_receive == $past(bus_req.wdata[6])))
    else $error("nonlinear bit not stored");

  // delimiter width alone picks maximum
  chk_dlm_max: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (frame_delimiter_width && !s_d.self_chk[5]) |=> (dlm.mode == tp_pkg::TP_DLM_MAX))
    else $error("delimiter not maximum");

  // trimmed delimiter figures
  chk_dlm_trim: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (frame_delimiter_width && s_d.self_chk[5])
    |=> (dlm.mode == tp_pkg::TP_DLM_TRIM && dlm.sof_low_etu == 4'hb && dlm.sof_high_etu == 4'h2))
    else $error("delimiter trim wrong");

  // self-test runs only when armed
  chk_selftest_run: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (selftest_cmd && !selftest_armed) |=> !selftest_run)
    else $error("self-test ran unarmed");

  // arm code written is armed one cycle later
  chk_selftest_arm: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_req.wr && bus_req.addr == `TP_ADDR_SELF_CHK && bus_req.wdata[3:0] == 4'h9) |=> selftest_armed)
    else $error("self-test not armed");

  // aux line bit set turns the uart lines back on
  chk_uart_aux_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_req.wr && bus_req.addr == `TP_ADDR_PIN_EN && bus_req.wdata[`TP_BIT_UART_AUX])
    |=> uart_aux_line_enable)
    else $error("uart aux lines not enabled");

  // a clear enable bit keeps its pin an input
  chk_pin_en_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!s_q.pin_en[2])
    |=> pin_oe_n[2])
    else $error("pin 2 driven without its enable");

  // port i/o on drives an enabled pin that nothing else claims
  chk_io_on_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (serial_host && s_q.pin_val[`TP_BIT_IO_EN] && s_q.pin_en[3])
    |=> !pin_oe_n[3])
    else $error("pin 3 not driven with port i/o on");

  // uart with aux lines keeps pins 5 and 6 as inputs
  chk_uart_narrow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (host_if == tp_pkg::TP_HOST_UART && s_q.pin_en[`TP_BIT_UART_AUX])
    |=> (pin_oe_n[6:5] == 2'h3))
    else $error("pin 5 or 6 driven under uart with aux lines");

  // uart without aux lines frees pin 6
  chk_uart_wide: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (host_if == tp_pkg::TP_HOST_UART && !s_q.pin_en[`TP_BIT_UART_AUX] && port_io_enable && s_q.pin_en[6])
    |=> !pin_oe_n[6])
    else $error("pin 6 not driven under uart without aux lines");

  // value read shows the stored byte while port i/o is off
  chk_value_stored: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_req.rd && bus_req.addr == `TP_ADDR_PIN_VAL && !port_io_enable)
    |=> (rdata == $past(s_q.pin_val)))
    else $error("pin value read not stored byte");

  // probe select field follows a write
  chk_probe_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_req.wr && bus_req.addr == `TP_ADDR_PROBE_SEL)
    |=> (s_q.probe_sel[4:0] == $past(bus_req.wdata[4:0])))
    else $error("probe select not stored");

  // clock-select bit follows a write
  chk_aux_clk_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_req.wr && bus_req.addr == `TP_ADDR_CLK_SEL)
    |=> (s_q.clk_sel[`TP_BIT_AUX_CLK] == $past(bus_req.wdata[`TP_BIT_AUX_CLK])))
    else $error("aux clock select not stored");

  // width clear always gives minimum delimiters
  chk_dlm_min: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!frame_delimiter_width)
    |=> (dlm.mode == tp_pkg::TP_DLM_MIN))
    else $error("delimiter not minimum");

  // trimmed delimiter carrier-cycle figures
  chk_dlm_trim_cyc: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (frame_delimiter_width && s_d.self_chk[`TP_BIT_DLM_ADJ])
    |=> (dlm.low_minus_cyc == `TP_TRIM_CYC && dlm.high_plus_cyc == `TP_TRIM_CYC))
    else $error("delimiter trim cycles wrong");

  // off code written disarms one cycle later
  chk_selftest_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_req.wr && bus_req.addr == `TP_ADDR_SELF_CHK && bus_req.wdata[3:0] == `TP_ST_OFF)
    |=> !selftest_armed)
    else $error("self-test not disarmed");

  // command while armed starts the self-test
  chk_selftest_go: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (selftest_cmd && selftest_armed)
    |=> selftest_run)
    else $error("self-test did not run");

endmodule // tp_test_page

// ===== hw/tp_consts.svh
// offsets, field positions, reset values and fixed figures of the test-page register group
// How it works
// - aux bit low disables uart aux lines
// - enable bits 6..0 enable pin drivers
// - pin drivers only with serial host
// - spi or uart with aux: pins 0-4
// - value bit 7 turns port i/o on
// - pin drives value only when enabled
// - aux clock on pin one blocks i/o
// - value read: pin levels or stored
// - probe view read-only, shows selected bus
// - nonlinear bit sets receiver nonlinear mode
// - adjust low: width picks max/min delimiters
// - adjust and width: trimmed delimiter lengths
// - self-test armed by 1001, off by 0000
// - probe select field chooses probe bus
// - clock-select bit puts aux clock on pin one
`ifndef TP_CONSTS_SVH
`define TP_CONSTS_SVH

// register offsets on the 6-bit address port
`define TP_ADDR_CLK_SEL    6'h31
`define TP_ADDR_PROBE_SEL  6'h32
`define TP_ADDR_PIN_EN     6'h33
`define TP_ADDR_PIN_VAL    6'h34
`define TP_ADDR_PROBE_VIEW 6'h35
`define TP_ADDR_SELF_CHK   6'h36

// reset values
`define TP_RST_CLK_SEL     8'h00
`define TP_RST_PROBE_SEL   8'h00
`define TP_RST_PIN_EN      8'h80
`define TP_RST_PIN_VAL     8'h00
`define TP_RST_SELF_CHK    8'h40

// writable masks, reserved bits read as zero
`define TP_WMASK_CLK_SEL   8'h3f
`define TP_WMASK_SELF_CHK  8'h6f

// field positions
`define TP_BIT_UART_AUX    7
`define TP_BIT_IO_EN       7
`define TP_BIT_AUX_CLK     3
`define TP_BIT_NONLIN      6
`define TP_BIT_DLM_ADJ     5
`define TP_PIN_ONE         1

// pin masks
`define TP_PINS_NARROW     7'h1f
`define TP_PINS_ALL        7'h7f

// self-test codes
`define TP_ST_ARM          4'h9
`define TP_ST_OFF          4'h0

// trimmed delimiter figures: etu counts and carrier-cycle trims
`define TP_SOF_LOW_ETU     4'hb
`define TP_SOF_HIGH_ETU    4'h2
`define TP_TRIM_CYC        4'h8

`endif

// ===== hw/tp_pkg.sv
// types shared by the test-page register group
package tp_pkg;

  // which host interface the chip detected
  typedef enum logic [1:0] {
    TP_HOST_PARALLEL = 2'h0,
    TP_HOST_SPI      = 2'h1,
    TP_HOST_UART     = 2'h2,
    TP_HOST_I2C      = 2'h3
  } tp_host_if_t;

  // delimiter generation modes, one-hot
  typedef enum logic [2:0] {
    TP_DLM_MIN  = 3'h1,
    TP_DLM_MAX  = 3'h2,
    TP_DLM_TRIM = 3'h4
  } tp_dlm_mode_t;

  // register port request
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tp_bus_req_t;

  // delimiter control toward the framer
  typedef struct packed {
    tp_dlm_mode_t mode;
    logic [3:0]   sof_low_etu;
    logic [3:0]   low_minus_cyc;
    logic [3:0]   sof_high_etu;
    logic [3:0]   high_plus_cyc;
  } tp_dlm_t;

  // whole state of the register group
  typedef struct packed {
    logic [7:0] clk_sel;
    logic [7:0] probe_sel;
    logic [7:0] pin_en;
    logic [7:0] pin_val;
    logic [7:0] self_chk;
    logic [7:0] rdata;
    logic       armed;
    logic       run;
    tp_dlm_t    dlm;
  } tp_state_t;

  // state of one pin cell
  typedef struct packed {
    logic out;
    logic oe_n;
  } tp_pin_state_t;

endpackage

// ===== hw/tp_pin_cell.sv
// one general i/o pin output stage with an alternate function
`timescale 1ns/1ps
`include "tp_consts.svh"

module tp_pin_cell (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // general i/o request
  input  wire logic io_drive,
  input  wire logic io_value,
  // alternate function, wins over general i/o
  input  wire logic alt_drive,
  input  wire logic alt_value,
  // pin side
  output logic      pin_out,
  output logic      pin_oe_n
);

  tp_pkg::tp_pin_state_t s_q;
  tp_pkg::tp_pin_state_t s_d;

  // pick the source; undriven pins float as inputs
  always_comb
  begin
    s_d = s_q;
    s_d.oe_n = ~(io_drive | alt_drive);
    s_d.out  = alt_drive ? alt_value : (io_drive & io_value);
  end

  // registered so the pad sees no glitches
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '{out: 1'b0, oe_n: 1'b1};
    else
      s_q <= s_d;
  end

  assign pin_out  = s_q.out;
  assign pin_oe_n = s_q.oe_n;

endmodule // tp_pin_cell

// ===== hw/tp_probe_mux.sv
// selects one of the internal probe buses
`timescale 1ns/1ps

module tp_probe_mux (
  // inputs
  input  wire logic [255:0] probe_buses,
  input  wire logic [4:0]   sel,
  // selected bus
  output logic      [7:0]   view
);

  logic [7:0] base;

  // bit offset is the select times eight
  always_comb
  begin
    base = {sel, 3'h0};
    view = probe_buses[base +: 8];
  end

endmodule // tp_probe_mux

// ===== verification/tp_pin_env.sv
// board-side model of the spare data pins: pull-ups where nobody drives
`timescale 1ns/1ps

module tp_pin_env (
  // pin side of the block
  input  wire logic [6:0] pin_out,
  input  wire logic [6:0] pin_oe_n,
  // resolved wire levels
  output logic      [6:0] pin_lvl
);
  // released pins float up, so an undriven pin never reads as a stale value
  always_comb
  begin
    for (int i = 0; i < 7; i++)
      pin_lvl[i] = pin_oe_n[i] ? 1'b1 : pin_out[i];
  end
endmodule // tp_pin_env

// ===== verification/tp_test_page_tb.sv
// self-checking bench for the test-page register group
`timescale 1ns/1ps

module tp_test_page_tb;
  logic                 sys_clk;
  logic                 rst_n;
  tp_pkg::tp_bus_req_t  bus_req;
  logic [7:0]           rdata;
  tp_pkg::tp_host_if_t  host_if;
  logic [6:0]           pin_lvl;
  logic [6:0]           pin_out;
  logic [6:0]           pin_oe_n;
  logic                 aux_clk;
  logic [255:0]         probe_buses;
  logic                 fdw;
  logic                 cmd;
  logic                 uart_aux;
  logic                 nonlin;
  tp_pkg::tp_dlm_t      dlm;
  tp_pkg::tp_dlm_t      edlm;
  logic                 armed;
  logic                 run;
  logic [6:0]           use_m;
  logic [6:0]           drv;
  int                   fails;
  int                   cmp_count;

  tp_test_page uut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata), .host_if(host_if),
    .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .aux_module_clk(aux_clk),
    .probe_buses(probe_buses), .frame_delimiter_width(fdw), .selftest_cmd(cmd),
    .uart_aux_line_enable(uart_aux), .nonlinear_receive(nonlin), .dlm(dlm),
    .selftest_armed(armed), .selftest_run(run));

  tp_pin_env env (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_lvl(pin_lvl));

  // 125 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic final_report();
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [18:0] e, input logic [18:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req.wr    <= 1'b1;
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    @(posedge sys_clk);
    bus_req.wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, input logic [7:0] e, input string nm);
    @(posedge sys_clk);
    bus_req.rd   <= 1'b1;
    bus_req.addr <= a;
    @(posedge sys_clk);
    bus_req.rd   <= 1'b0;
    #1 chk(nm, {11'h000, e}, {11'h000, rdata});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // hang guard
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    final_report();
  end

  initial
  begin
    bus_req = '0;
    host_if = tp_pkg::TP_HOST_PARALLEL;
    aux_clk = 1'b0;
    fdw     = 1'b0;
    cmd     = 1'b0;
    rst_n   = 1'b0;
    fails   = 0;
    cmp_count = 0;
    for (int k = 0; k < 32; k++)
      probe_buses[8*k +: 8] = 8'(k * 37 + 5);
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset values and refusals
    rd(6'h33, 8'h80, "pin_en");
    rd(6'h34, 8'h00, "pin_val");
    rd(6'h36, 8'h40, "self_chk");
    rd(6'h31, 8'h00, "clk_sel");
    rd(6'h3f, 8'h00, "unmapped");
    chk("oe_rst", 19'h7f, {12'h000, pin_oe_n});
    chk("nonlin_rst", 19'h1, {18'h0, nonlin});
    // host kinds against aux line bit, partial enable pattern
    for (int h = 0; h < 4; h++)
      for (int x = 0; x < 2; x++)
      begin
        @(posedge sys_clk) host_if <= tp_pkg::tp_host_if_t'(h);
        wr(6'h33, {x[0], 7'h6d});
        wr(6'h34, 8'hd5);
        settle(3);
        use_m = (h == 1 || (h == 2 && x == 1)) ? 7'h1f : 7'h7f;
        drv   = (h != 0) ? (7'h6d & use_m) : 7'h00;
        chk("uart_aux", {18'h0, x[0]}, {18'h0, uart_aux});
        chk("oe_n", {12'h0, ~drv}, {12'h0, pin_oe_n});
        chk("pin_out", {12'h0, 7'h55 & drv}, {12'h0, pin_out & drv});
        rd(6'h34, (h != 0) ? {1'b1, (7'h55 & drv) | ~drv} : 8'hd5, "pin_rd");
      end
    // aux clock on pin one wins over general i/o
    @(posedge sys_clk) host_if <= tp_pkg::TP_HOST_SPI;
    wr(6'h31, 8'hff);
    rd(6'h31, 8'h3f, "clk_sel_mask");
    wr(6'h31, 8'h08);
    wr(6'h33, 8'h7f);
    wr(6'h34, 8'h80);
    aux_clk <= 1'b1;
    settle(3);
    chk("pin1_oe", 19'h0, {18'h0, pin_oe_n[1]});
    chk("pin1_clk_hi", 19'h1, {18'h0, pin_out[1]});
    @(posedge sys_clk) aux_clk <= 1'b0;
    settle(2);
    chk("pin1_clk_lo", 19'h0, {18'h0, pin_out[1]});
    @(posedge sys_clk) host_if <= tp_pkg::TP_HOST_PARALLEL;
    settle(3);
    chk("pin1_par", 19'h1, {18'h0, pin_oe_n[1]});
    // probe view, writes to it refused
    wr(6'h35, 8'haa);
    for (int k = 0; k < 32; k++)
    begin
      wr(6'h32, {3'h7, 5'(k)});
      rd(6'h35, 8'(k * 37 + 5), "probe");
    end
    // receiver mode and masks
    wr(6'h36, 8'hff);
    rd(6'h36, 8'h6f, "self_chk_mask");
    wr(6'h36, 8'h00);
    settle(1);
    chk("nonlin_off", 19'h0, {18'h0, nonlin});
    // delimiter modes
    for (int c = 0; c < 4; c++)
    begin
      @(posedge sys_clk) fdw <= c[0];
      wr(6'h36, {2'b01, c[1], 5'h00});
      settle(2);
      edlm      = '0;
      edlm.mode = c[0] ? (c[1] ? tp_pkg::TP_DLM_TRIM : tp_pkg::TP_DLM_MAX) : tp_pkg::TP_DLM_MIN;
      if (c == 3)
        edlm = '{tp_pkg::TP_DLM_TRIM, 4'hb, 4'h8, 4'h2, 4'h8};
      chk("dlm", edlm, dlm);
      chk("nonlin_on", 19'h1, {18'h0, nonlin});
    end
    // self-test: near code refused, arm code then off code
    wr(6'h36, 8'h08);
    settle(1);
    chk("armed_near", 19'h0, {18'h0, armed});
    wr(6'h36, 8'h09);
    settle(1);
    chk("armed", 19'h1, {18'h0, armed});
    @(posedge sys_clk);
    cmd <= 1'b1;
    @(posedge sys_clk);
    cmd <= 1'b0;
    #1 chk("run", 19'h1, {18'h0, run});
    settle(1);
    chk("run_end", 19'h0, {18'h0, run});
    wr(6'h36, 8'h00);
    settle(1);
    chk("disarmed", 19'h0, {18'h0, armed});
    @(posedge sys_clk) cmd <= 1'b1;
    @(posedge sys_clk);
    cmd <= 1'b0;
    #1 chk("run_off", 19'h0, {18'h0, run});
    settle(1);
    chk("run_off2", 19'h0, {18'h0, run});
    final_report();
  end
endmodule // tp_test_page_tb
